// ===== hdl/wdt_reset_gen.sv
// Watchdog and reset generator with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module wdt_reset_gen #(
    parameter int unsigned LVD_HOLD  = wdt_pkg::LVD_HOLD_CYC,
    parameter int unsigned WDT_COUNT = wdt_pkg::WDT_OVF_COUNT,
    parameter int unsigned PULSE_MC  = wdt_pkg::WDT_PULSE_MC
) (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // Reset sources
    input  wire logic        ext_rst_n_i,
    input  wire logic        low_supply_i,
    // Internal reset out
    output var  logic        sys_rst_n_o,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    output var  logic [31:0] hrdata_o,
    output var  logic        hreadyout_o,
    output var  logic        hresp_o
);

    localparam int unsigned LVD_W   = $clog2(LVD_HOLD + 1);
    localparam int unsigned PULSE_W = $clog2(PULSE_MC + 1);
    localparam int unsigned EXT_W   = $clog2(wdt_pkg::EXT_MIN_CYC + 1);
    localparam int unsigned WB      = wdt_pkg::WDT_BITS;

    localparam logic [EXT_W-1:0]   EXT_HIT    = EXT_W'(wdt_pkg::EXT_MIN_CYC - 1);
    localparam logic [LVD_W-1:0]   LVD_LOAD   = LVD_W'(LVD_HOLD);
    localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(PULSE_MC - 1);
    localparam logic [WB-1:0]      WDT_TOP    = WB'(WDT_COUNT - 1);

    // Reset release
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Pin synchronisers
    logic ext_n_s;
    logic lvd_s;

    sync2 #(.RESET_VAL(1'b1)) u_sync_ext (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_q),
        .async_i (ext_rst_n_i),
        .sync_o  (ext_n_s)
    );

    sync2 #(.RESET_VAL(1'b0)) u_sync_lvd (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_q),
        .async_i (low_supply_i),
        .sync_o  (lvd_s)
    );

    // Machine cycle time base, free running through idle
    logic tick;

    mc_tick_gen #(.DIV(wdt_pkg::MC_CLKS)) u_tick (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_q),
        .tick_o  (tick)
    );

    // Bus address phase
    logic       wr_pend_q;
    logic [9:0] addr_q;
    logic [31:0] rdata_q;

    wire        acc      = hsel_i & htrans_i[1] & hready_i;
    wire        hi_zero  = (haddr_i[31:10] == 22'h00_0000);
    wire        rd_key   = hi_zero & (haddr_i[9:0] == wdt_pkg::KEY_ADDR);
    wire        rd_stat  = hi_zero & (haddr_i[9:0] == wdt_pkg::STATUS_ADDR);
    wire        wr_clear = wr_pend_q & (addr_q == wdt_pkg::CLEAR_ADDR);
    wire        wr_key   = wr_pend_q & (addr_q == wdt_pkg::KEY_ADDR);
    wire        wr_stat  = wr_pend_q & (addr_q == wdt_pkg::STATUS_ADDR);
    wire [7:0]  wbyte    = hwdata_i[7:0];

    // Block state
    logic                    sys_rst_q;
    logic [7:0]              key_q;
    logic [WB-1:0]           cnt_q;
    wdt_pkg::svc_state_t     svc_q;
    logic [EXT_W-1:0]        ext_cnt_q;
    logic [LVD_W-1:0]        lvd_cnt_q;
    logic                    pulse_q;
    logic [PULSE_W-1:0]      pcnt_q;
    logic [2:0]              cause_q;

    // Enable and service decode
    wire wdt_en   = (key_q != wdt_pkg::KEY_DISABLE);
    wire svc_done = wr_clear & (svc_q == wdt_pkg::SVC_ARMED)
                  & (wbyte == wdt_pkg::SVC_SECOND);
    wire wdt_clr  = sys_rst_q | svc_done;
    wire wdt_step = tick & wdt_en;
    wire wdt_ovf  = wdt_step & (cnt_q == WDT_TOP) & ~wdt_clr;

    // Reset source decode
    wire ext_act  = ~ext_n_s & (ext_cnt_q == EXT_HIT);
    wire lvd_act  = lvd_s | (lvd_cnt_q != '0);
    wire pulse_end = pulse_q & tick & (pcnt_q == PULSE_LAST);
    wire any_rst  = ext_act | lvd_act | pulse_q;
    localparam int unsigned ST_HI = wdt_pkg::ST_CAUSE + 2;

    wire [2:0] cause_set = {lvd_act, ext_act, pulse_q};
    wire [2:0] cause_clr = wr_stat ? hwdata_i[ST_HI:wdt_pkg::ST_CAUSE] : 3'b000;

    wire [31:0] status = {27'h000_0000, cause_q, svc_q == wdt_pkg::SVC_ARMED, wdt_en};
    wire [31:0] rd_mux = rd_key  ? {24'h00_0000, key_q} :
                         rd_stat ? status : 32'h0000_0000;

    // Service tracker next state
    wdt_pkg::svc_state_t svc_d;

    always_comb
    begin
        svc_d = svc_q;
        if (sys_rst_q)
            svc_d = wdt_pkg::SVC_IDLE;
        else if (wr_clear)
        begin
            unique case (svc_q)
                wdt_pkg::SVC_IDLE:
                    svc_d = (wbyte == wdt_pkg::SVC_FIRST) ? wdt_pkg::SVC_ARMED
                                                          : wdt_pkg::SVC_IDLE;
                wdt_pkg::SVC_ARMED:
                    svc_d = (wbyte == wdt_pkg::SVC_FIRST) ? wdt_pkg::SVC_ARMED
                                                          : wdt_pkg::SVC_IDLE;
            endcase
        end
    end

    // Bus slave registers
    always_ff @(posedge mclk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            wr_pend_q <= 1'b0;
            addr_q    <= 10'h000;
            rdata_q   <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_q <= acc & hwrite_i;
            addr_q    <= hi_zero ? haddr_i[9:0] : 10'h3FF;
            rdata_q   <= (acc & ~hwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end

    // Watchdog state, cleared by the internal reset
    always_ff @(posedge mclk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            key_q <= wdt_pkg::KEY_RST;
            cnt_q <= '0;
            svc_q <= wdt_pkg::SVC_IDLE;
        end
        else
        begin
            if (sys_rst_q)
                key_q <= wdt_pkg::KEY_RST;
            else if (wr_key)
                key_q <= wbyte;
            if (wdt_clr)
                cnt_q <= '0;
            else if (wdt_step)
                cnt_q <= cnt_q + 1'b1;
            svc_q <= svc_d;
        end
    end

    // Reset generation, kept out of the internal reset
    always_ff @(posedge mclk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ext_cnt_q <= '0;
            lvd_cnt_q <= '0;
            pulse_q   <= 1'b0;
            pcnt_q    <= '0;
            sys_rst_q <= 1'b1;
            cause_q   <= 3'b000;
        end
        else
        begin
            if (ext_n_s)
                ext_cnt_q <= '0;
            else if (ext_cnt_q != EXT_HIT)
                ext_cnt_q <= ext_cnt_q + 1'b1;
            if (lvd_s)
                lvd_cnt_q <= LVD_LOAD;
            else if (lvd_cnt_q != '0)
                lvd_cnt_q <= lvd_cnt_q - 1'b1;
            if (wdt_ovf)
            begin
                pulse_q <= 1'b1;
                pcnt_q  <= '0;
            end
            else if (pulse_end)
                pulse_q <= 1'b0;
            else if (pulse_q & tick)
                pcnt_q  <= pcnt_q + 1'b1;
            sys_rst_q <= any_rst;
            cause_q   <= (cause_q & ~cause_clr) | cause_set;
        end
    end

    assign sys_rst_n_o = ~sys_rst_q;
    assign hrdata_o    = rdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // Checks
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_q);

    a_ext_reset_in: assert property (ext_act |=> sys_rst_q)
        else $error("Recognised pin reset did not reach the internal reset");

    a_ext_short_pin: assert property (ext_n_s ##1 !ext_n_s [*8] |-> !ext_act)
        else $error("Pin reset taken before the minimum low time");

    a_lvd_hold_on: assert property ($fell(lvd_s) |-> sys_rst_q [*8])
        else $error("Internal reset dropped right after supply recovered");

    a_wdt_ovf_rst: assert property (wdt_ovf |=> pulse_q ##1 sys_rst_q)
        else $error("Watchdog overflow did not start the reset pulse");

    a_pulse_len: assert property ($fell(pulse_q) |-> $past(pcnt_q) == PULSE_LAST)
        else $error("Watchdog reset pulse ended early");

    a_wdt_step_one: assert property (
        wdt_step && !wdt_clr |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("Watchdog counter did not step by one");

    a_key_stop: assert property (
        key_q == wdt_pkg::KEY_DISABLE && !wdt_clr |=> $stable(cnt_q))
        else $error("Disabled watchdog kept counting");

    a_svc_clears: assert property (svc_done |=> cnt_q == '0 && svc_q == wdt_pkg::SVC_IDLE)
        else $error("Service sequence did not restart the count");

    a_bad_second: assert property (
        wr_clear && svc_q == wdt_pkg::SVC_ARMED && wbyte != wdt_pkg::SVC_SECOND
        && wbyte != wdt_pkg::SVC_FIRST |=> svc_q == wdt_pkg::SVC_IDLE)
        else $error("Broken service sequence stayed armed");

    a_rst_clears: assert property (
        sys_rst_q |=> cnt_q == '0 && key_q == wdt_pkg::KEY_RST)
        else $error("Internal reset left watchdog state behind");

endmodule // wdt_reset_gen
`default_nettype wire

// ===== hdl/wdt_pkg.sv
// Constants, types and register map of the watchdog and reset generator
package wdt_pkg;

    // Clock and time base
    localparam int unsigned CLK_MHZ      = 200;
    localparam int unsigned MC_CLKS      = 12;
    localparam int unsigned EXT_MIN_MC   = 2;
    localparam int unsigned EXT_MIN_CYC  = EXT_MIN_MC * MC_CLKS;
    localparam int unsigned LVD_HOLD_US  = 2000;
    localparam int unsigned LVD_HOLD_CYC = LVD_HOLD_US * CLK_MHZ;

    // Watchdog
    localparam int unsigned WDT_BITS      = 19;
    localparam int unsigned WDT_OVF_COUNT = 524288;
    localparam int unsigned WDT_PULSE_MC  = 2049;
    localparam logic [7:0]  SVC_FIRST     = 8'h1E;
    localparam logic [7:0]  SVC_SECOND    = 8'hE1;
    localparam logic [7:0]  KEY_DISABLE   = 8'h55;
    localparam logic [7:0]  KEY_RST       = 8'h00;

    // Register indices and byte addresses
    localparam logic [7:0] CLEAR_IDX   = 8'hA6;
    localparam logic [7:0] KEY_IDX     = 8'hAE;
    localparam logic [7:0] STATUS_IDX  = 8'hB0;
    localparam logic [9:0] CLEAR_ADDR  = {CLEAR_IDX, 2'b00};
    localparam logic [9:0] KEY_ADDR    = {KEY_IDX, 2'b00};
    localparam logic [9:0] STATUS_ADDR = {STATUS_IDX, 2'b00};

    // Status fields
    localparam int unsigned ST_EN    = 0;
    localparam int unsigned ST_ARMED = 1;
    localparam int unsigned ST_CAUSE = 2;

    // Service sequence tracker
    typedef enum logic {
        SVC_IDLE  = 1'b0,
        SVC_ARMED = 1'b1
    } svc_state_t;

endpackage

// ===== hdl/sync2.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    // Level
    input  wire logic async_i,
    output var  logic sync_o
);

    logic meta_q;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= RESET_VAL;
            sync_o <= RESET_VAL;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule // sync2
`default_nettype wire

// ===== hdl/mc_tick_gen.sv
// Machine cycle tick from the system clock
`timescale 1ns/100ps
`default_nettype none
module mc_tick_gen #(
    parameter int unsigned DIV = wdt_pkg::MC_CLKS
) (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    // One-cycle tick every DIV clocks
    output var  logic tick_o
);

    localparam int unsigned W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    localparam logic [W:0]   GAP_LAST = (W+1)'(DIV - 1);

    logic [W-1:0] div_q;
    wire          wrap = (div_q == LAST);

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div_q  <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            div_q  <= wrap ? '0 : div_q + 1'b1;
            tick_o <= wrap;
        end
    end

    // Clocks since the last tick, saturating, for the period check
    logic [W:0] gap_q;
    logic       seen_q;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gap_q  <= '0;
            seen_q <= 1'b0;
        end
        else
        begin
            gap_q  <= tick_o ? '0 : ((gap_q == '1) ? gap_q : gap_q + 1'b1);
            seen_q <= seen_q | tick_o;
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    a_tick_period: assert property (tick_o && seen_q |-> gap_q == GAP_LAST)
        else $error("Machine cycle tick is not twelve clocks apart");

endmodule // mc_tick_gen
`default_nettype wire

// ===== tb/ext_rst_src.sv
// Model of the outside party that drives the reset pin
`timescale 1ns/100ps
`default_nettype none
module ext_rst_src (
    // Clock
    input  wire logic mclk_i,
    // Reset pin, pulled up whenever released
    output var  logic pin_n_o
);
    initial pin_n_o = 1'b1;

    // Pin low for whole clocks, then the pull-up wins
    task automatic hold_low(input int unsigned n);
        pin_n_o <= 1'b0;
        repeat (n) @(posedge mclk_i);
        pin_n_o <= 1'b1;
    endtask
endmodule // ext_rst_src
`default_nettype wire

// ===== tb/tb_wdt_reset_gen.sv
// Self-checking bench for the watchdog and reset generator
`timescale 1ns/100ps
`default_nettype none
module tb_wdt_reset_gen;
    localparam int unsigned LVD  = 50;
    localparam int unsigned WCNT = 64;
    localparam int unsigned PMC  = 4;
    localparam int unsigned MC   = wdt_pkg::MC_CLKS;
    localparam logic [9:0]  CLR  = wdt_pkg::CLEAR_ADDR;
    localparam logic [9:0]  KEY  = wdt_pkg::KEY_ADDR;
    localparam logic [9:0]  STA  = wdt_pkg::STATUS_ADDR;

    logic        mclk;
    logic        nrst_i;
    logic        ext_rst_n;
    logic        low_supply;
    logic        sys_rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic [31:0] rd;
    logic [7:0]  keys [6];
    int          fails;
    int          checked;
    int          lows;
    int          l0;
    int          n;

    wdt_reset_gen #(.LVD_HOLD(LVD), .WDT_COUNT(WCNT), .PULSE_MC(PMC)) wdt_reset_gen_i (
        .mclk_i(mclk), .nrst_i(nrst_i), .ext_rst_n_i(ext_rst_n),
        .low_supply_i(low_supply), .sys_rst_n_o(sys_rst_n), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp)
    );

    ext_rst_src ext_rst_src_i (.mclk_i(mclk), .pin_n_o(ext_rst_n));

    always #2.5 mclk = ~mclk;

    always @(posedge mclk)
        if (sys_rst_n === 1'b0)
            lows <= lows + 1;

    task automatic bus_op(input logic [9:0] a, input logic wr, input logic [7:0] d,
                          output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {22'h0, a};
        hwrite <= wr;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        q = hrdata;
    endtask

    task automatic bus_wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus_op(a, 1'b1, d, q);
    endtask

    task automatic bus_rd(input logic [9:0] a, output logic [31:0] q);
        bus_op(a, 1'b0, 8'h00, q);
    endtask

    task automatic service();
        bus_wr(CLR, wdt_pkg::SVC_FIRST);
        bus_wr(CLR, wdt_pkg::SVC_SECOND);
    endtask

    task automatic cmp_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_span(input string what, input int lo, input int hi, input int got);
        checked++;
        if (got < lo || got > hi)
        begin
            fails++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic wait_low(input int lim, output int t);
        t = 0;
        while (sys_rst_n !== 1'b0 && t < lim)
        begin
            @(posedge mclk);
            t++;
        end
    endtask

    task automatic wait_high(output int t);
        t = 0;
        while (sys_rst_n !== 1'b1 && t < 2000)
        begin
            @(posedge mclk);
            t++;
        end
        @(posedge mclk);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        finish_test();
    end

    initial
    begin
        mclk = 1'b0; nrst_i = 1'b0; low_supply = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000;
        htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0000_0000;
        fails = 0; checked = 0; lows = 0;
        keys = '{8'h55, 8'h54, 8'hD5, 8'hAA, 8'hFF, 8'h00};
        repeat (4) @(posedge mclk);
        nrst_i <= 1'b1;
        wait_high(n);
        bus_rd(KEY, rd); cmp_reg("key reset", 32'h0000_0000, rd);
        bus_wr(CLR, 8'hFF);
        bus_rd(CLR, rd); cmp_reg("clear read", 32'h0000_0000, rd);
        cmp_reg("clear read response", 32'h0000_0000, {31'h0, hresp});
        bus_rd(STA, rd); cmp_reg("enabled at start", 32'h0000_0001, rd & 32'h0000_0001);
        bus_rd(10'h3FC, rd); cmp_reg("unmapped read", 32'h0000_0000, rd);
        for (int i = 0; i < 6; i++)
        begin
            bus_wr(KEY, keys[i]);
            bus_rd(KEY, rd); cmp_reg("key readback", {24'h00_0000, keys[i]}, rd);
            bus_rd(STA, rd); cmp_reg("enable", {31'h0, keys[i] != 8'h55}, rd & 32'h0000_0001);
        end
        $display("test registers done");
        bus_wr(KEY, 8'h12);
        service();
        repeat (400) @(posedge mclk);
        bus_wr(CLR, wdt_pkg::SVC_FIRST);
        bus_rd(STA, rd); cmp_reg("armed", 32'h0000_0002, rd & 32'h0000_0002);
        bus_wr(CLR, 8'h00);
        bus_rd(STA, rd); cmp_reg("disarmed", 32'h0000_0000, rd & 32'h0000_0002);
        bus_wr(CLR, wdt_pkg::SVC_SECOND);
        wait_low(2000, n); cmp_span("overflow time", (WCNT-1)*MC-410, WCNT*MC-410+4, n);
        wait_high(n); cmp_span("overflow pulse", (PMC-1)*MC+1, PMC*MC+3, n);
        bus_rd(KEY, rd); cmp_reg("key after reset", 32'h0000_0000, rd);
        bus_rd(STA, rd); cmp_reg("cause watchdog", 32'h0000_0005, rd & 32'h0000_0007);
        bus_wr(STA, 8'h1C);
        $display("test overflow done");
        bus_wr(KEY, wdt_pkg::KEY_DISABLE);
        l0 = lows;
        repeat (2*WCNT*MC) @(posedge mclk);
        cmp_span("disabled no reset", 0, 0, lows - l0);
        bus_wr(KEY, 8'h00);
        service();
        l0 = lows;
        repeat (4)
        begin
            repeat (WCNT*MC/2) @(posedge mclk);
            service();
        end
        cmp_span("serviced no reset", 0, 0, lows - l0);
        $display("test service done");
        l0 = lows;
        ext_rst_src_i.hold_low(10);
        repeat (40) @(posedge mclk);
        cmp_span("short pin pulse", 0, 0, lows - l0);
        service();
        ext_rst_src_i.hold_low(wdt_pkg::EXT_MIN_CYC);
        wait_low(40, n); cmp_span("pin reset delay", 0, 39, n);
        wait_high(n);
        bus_rd(STA, rd); cmp_reg("cause pin", 32'h0000_0008, rd & 32'h0000_001C);
        bus_wr(STA, 8'h1C);
        $display("test pin done");
        service();
        low_supply <= 1'b1;
        repeat (10) @(posedge mclk);
        cmp_reg("low supply reset", 32'h0000_0000, {31'h0, sys_rst_n});
        low_supply <= 1'b0;
        wait_high(n); cmp_span("supply hold", LVD, LVD+6, n);
        bus_rd(STA, rd); cmp_reg("cause supply", 32'h0000_0010, rd & 32'h0000_001C);
        $display("test supply done");
        finish_test();
    end
endmodule // tb_wdt_reset_gen
`default_nettype wire
